// >>> prt_checker.sv
`timescale 1ns/100ps
// ----------------
// Port checks
// ----------------
module prt_checker (
	input wire core_clk,
	input wire reset_n,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	input wire [7:0] regRdData,
	input wire warmResetEvent,
	input wire nvmLoad,
	input wire powerDownAll,
	input wire [3:0] sequencerKickPulse,
	input wire [3:0] sequencerKickLevel,
	input wire spreadEnable,
	input wire [1:0] spreadDepth
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	reg [7:0] lastData;
	reg [7:0] lastTwo;
	wire kickWr = regWrite && regAddr == 8'h85;
	always @(posedge core_clk) begin
		lastData <= regWrData;
		lastTwo <= lastData;
	end
	a_kick_pulse: assert property (kickWr |=> sequencerKickPulse == lastData[3:0])
		else $error("kick pulse wrong");
	a_pulse_once: assert property (!kickWr |=> sequencerKickPulse == 4'h0)
		else $error("kick pulse without write");
	a_kick_level: assert property (kickWr ##1 !kickWr |=> sequencerKickLevel == lastTwo[7:4])
		else $error("kick level wrong");
	a_wipe_tally: assert property (regWrite && regAddr == 8'h84 && regWrData[4] && !warmResetEvent
		##1 regRead && regAddr == 8'h83 && !warmResetEvent |=> regRdData == 8'h00)
		else $error("tally not wiped");
	a_tally_upper: assert property (regRead && regAddr == 8'h83 |=> regRdData[7:4] == 4'h0)
		else $error("tally upper bits set");
	a_wipe_reads: assert property (regRead && regAddr == 8'h84 |=> regRdData[7:4] == 4'h0)
		else $error("wipe bit reads one");
	a_kick_readback: assert property (regRead && regAddr == 8'h85 |=> regRdData[3:0] == 4'h0)
		else $error("pulse kick bits read back set");
	a_depth_code: assert property (spreadDepth != 2'h3)
		else $error("reserved depth driven");
	a_spread_off: assert property (!spreadEnable |-> spreadDepth == 2'h0)
		else $error("depth while disabled");
	a_limit_zero: assert property (regWrite && regAddr == 8'h84 && regWrData[3:0] == 4'h0
		&& !nvmLoad |-> ##2 !powerDownAll)
		else $error("power down with zero limit");
endmodule // prt_checker

bind prt_recovery_trigger_regs prt_checker uut_chk (.*);

// >>> prt_defines.vh
`ifndef PRT_DEFINES_VH
`define PRT_DEFINES_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PRT_TALLY_STATUS_ADDR 8'h83
`define PRT_TALLY_CONTROL_ADDR 8'h84
`define PRT_KICKS_ADDR 8'h85
`define PRT_SLEEP_ADDR 8'h86
`define PRT_CONV_RESET_ADDR 8'h87
`define PRT_SPREAD_ADDR 8'h88
`define PRT_FREQ_ADDR 8'h8a

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PRT_RESET_BYTE 8'h00
`define PRT_RESET_NIBBLE 4'h0

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PRT_TALLY_MSB 3
`define PRT_WIPE_BIT 4
`define PRT_LIMIT_MSB 3
`define PRT_PULSE_KICK_MSB 3
`define PRT_LEVEL_KICK_LSB 4
`define PRT_LEVEL_KICK_MSB 7
`define PRT_SLEEP_ONE_BIT 0
`define PRT_SLEEP_TWO_BIT 1
`define PRT_SS_EN_BIT 2
`define PRT_SS_DEPTH_MSB 1

// ----------------------------------------
// Encodings
// ----------------------------------------
`define PRT_DEPTH_NONE 2'h0
`define PRT_DEPTH_RESERVED 2'h3
`define PRT_FREQ_2M2 2'h0
`define PRT_FREQ_4M4 2'h1
`define PRT_FREQ_8M8 2'h2

`endif

// >>> prt_recovery_trigger_regs.v
// Notes on behaviour
// - Read-only 4-bit tally in bits 3:0 counts warm resets, saturating at 15.
// - Writing one to tally_wipe bit 4 zeroes the tally.
// - The wipe bit clears itself and always reads back zero.
// - Writable 4-bit limit, default from NVM; tally reaching a nonzero limit powers down all rails.
// - Writing one to kick bits 0..3 pulses the sequencer trigger, then self-clears.
// - Kick bits 7..4 are plain storage whose levels feed the sequencer.
// - Sleep register bit 1 stands in for the second sleep input level.
// - Sleep register bit 0 stands in for the first sleep input level.
// - Converter reset bits 3..0 drive converter four..one logic resets, NVM defaults.
// - Spread bit 2 enables spread-spectrum modulation, NVM default.
// - Depth 00 none, 01 6.3 percent, 10 8.4 percent, 11 reserved.
// - Frequency field 00 2.2 MHz, 01 4.4 MHz, 10 and 11 8.8 MHz.
`timescale 1ns/100ps
`include "prt_defines.vh"

module prt_recovery_trigger_regs #(
	parameter CONVERTERS = 4
) (
	input wire core_clk,
	input wire reset_n,
	input wire [7:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWrite,
	input wire regRead,
	output reg [7:0] regRdData,
	input wire warmResetEvent,
	input wire nvmLoad,
	input wire [3:0] nvmTallyLimit,
	input wire [3:0] nvmConverterResets,
	input wire nvmSpreadEnable,
	input wire [1:0] nvmSpreadDepth,
	input wire [7:0] nvmFrequency,
	output reg powerDownAll,
	output reg [3:0] sequencerKickPulse,
	output reg [3:0] sequencerKickLevel,
	output reg sleepOneCopy,
	output reg sleepTwoCopy,
	output reg [3:0] converterLogicReset,
	output reg spreadEnable,
	output reg [1:0] spreadDepth,
	output reg [2*CONVERTERS-1:0] converterFrequency
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	reg resetSyncA;
	reg resetSync;

	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			resetSyncA <= 1'b0;
			resetSync <= 1'b0;
		end else begin
			resetSyncA <= 1'b1;
			resetSync <= resetSyncA;
		end
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function [1:0] freqClass;
		input [1:0] code;
		begin
			if (code == `PRT_FREQ_2M2)
				freqClass = `PRT_FREQ_2M2;
			else if (code == `PRT_FREQ_4M4)
				freqClass = `PRT_FREQ_4M4;
			else
				freqClass = `PRT_FREQ_8M8;
		end
	endfunction

	function [1:0] depthUsed;
		input [1:0] code;
		begin
			if (code == `PRT_DEPTH_RESERVED)
				depthUsed = `PRT_DEPTH_NONE;
			else
				depthUsed = code;
		end
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [3:0] tally;
	reg [3:0] tallyLimit;
	reg [3:0] levelKicks;
	reg [1:0] sleepCopies;
	reg [3:0] convResets;
	reg ssEnable;
	reg [1:0] ssDepth;
	reg [7:0] freqSelect;
	reg [3:0] next_tally;

	wire wrCtl = regWrite && (regAddr == `PRT_TALLY_CONTROL_ADDR);
	wire wrKick = regWrite && (regAddr == `PRT_KICKS_ADDR);
	wire wrSleep = regWrite && (regAddr == `PRT_SLEEP_ADDR);
	wire wrConv = regWrite && (regAddr == `PRT_CONV_RESET_ADDR);
	wire wrSpread = regWrite && (regAddr == `PRT_SPREAD_ADDR);
	wire wrFreq = regWrite && (regAddr == `PRT_FREQ_ADDR);

	// The tally saturates at its top value rather than wrapping
	// Wipe first, then the event counts, so a coincident warm reset is kept
	always @* begin
		next_tally = tally;
		if (wrCtl && regWrData[`PRT_WIPE_BIT])
			next_tally = `PRT_RESET_NIBBLE;
		if (warmResetEvent && next_tally != 4'hf)
			next_tally = next_tally + 4'h1;
	end

	always @(posedge core_clk or negedge resetSync) begin
		if (!resetSync) begin
			tally <= `PRT_RESET_NIBBLE;
			tallyLimit <= `PRT_RESET_NIBBLE;
			levelKicks <= `PRT_RESET_NIBBLE;
			sleepCopies <= 2'h0;
			convResets <= `PRT_RESET_NIBBLE;
			ssEnable <= 1'b0;
			ssDepth <= 2'h0;
			freqSelect <= `PRT_RESET_BYTE;
		end else begin
			tally <= next_tally;
			// Pulse kick bits are not stored; only the level bits are
			if (wrKick)
				levelKicks <= regWrData[`PRT_LEVEL_KICK_MSB:`PRT_LEVEL_KICK_LSB];
			if (wrSleep)
				sleepCopies <= regWrData[`PRT_SLEEP_TWO_BIT:`PRT_SLEEP_ONE_BIT];
			// A default load wins over a coincident software write
			if (nvmLoad) begin
				tallyLimit <= nvmTallyLimit;
				convResets <= nvmConverterResets;
				ssEnable <= nvmSpreadEnable;
				ssDepth <= nvmSpreadDepth;
				freqSelect <= nvmFrequency;
			end else begin
				if (wrCtl)
					tallyLimit <= regWrData[`PRT_LIMIT_MSB:0];
				if (wrConv)
					convResets <= regWrData[3:0];
				if (wrSpread) begin
					ssEnable <= regWrData[`PRT_SS_EN_BIT];
					ssDepth <= regWrData[`PRT_SS_DEPTH_MSB:0];
				end
				if (wrFreq)
					freqSelect <= regWrData;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always @(posedge core_clk or negedge resetSync) begin
		if (!resetSync) begin
			regRdData <= `PRT_RESET_BYTE;
		end else if (regRead) begin
			if (regAddr == `PRT_TALLY_STATUS_ADDR)
				regRdData <= {4'h0, tally};
			else if (regAddr == `PRT_TALLY_CONTROL_ADDR)
				regRdData <= {4'h0, tallyLimit};
			else if (regAddr == `PRT_KICKS_ADDR)
				// Self-clearing kick bits always read back as zero
				regRdData <= {levelKicks, `PRT_RESET_NIBBLE};
			else if (regAddr == `PRT_SLEEP_ADDR)
				regRdData <= {6'h00, sleepCopies};
			else if (regAddr == `PRT_CONV_RESET_ADDR)
				regRdData <= {4'h0, convResets};
			else if (regAddr == `PRT_SPREAD_ADDR)
				regRdData <= {5'h00, ssEnable, ssDepth};
			else if (regAddr == `PRT_FREQ_ADDR)
				regRdData <= freqSelect;
			else
				regRdData <= `PRT_RESET_BYTE;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	always @(posedge core_clk or negedge resetSync) begin
		if (!resetSync) begin
			powerDownAll <= 1'b0;
			sequencerKickPulse <= `PRT_RESET_NIBBLE;
			sequencerKickLevel <= `PRT_RESET_NIBBLE;
			sleepOneCopy <= 1'b0;
			sleepTwoCopy <= 1'b0;
			converterLogicReset <= `PRT_RESET_NIBBLE;
			spreadEnable <= 1'b0;
			spreadDepth <= 2'h0;
		end else begin
			// A zero limit means no power-down threshold
			powerDownAll <= (tallyLimit != 4'h0) && (tally >= tallyLimit);
			// One-cycle kick pulse straight from the write strobe
			sequencerKickPulse <= wrKick ? regWrData[`PRT_PULSE_KICK_MSB:0] : 4'h0;
			sequencerKickLevel <= levelKicks;
			sleepOneCopy <= sleepCopies[0];
			sleepTwoCopy <= sleepCopies[1];
			converterLogicReset <= convResets;
			spreadEnable <= ssEnable;
			spreadDepth <= ssEnable ? depthUsed(ssDepth) : `PRT_DEPTH_NONE;
		end
	end

	genvar c;
	generate
		for (c = 0; c < CONVERTERS; c = c + 1) begin : gFreq
			always @(posedge core_clk or negedge resetSync) begin
				if (!resetSync)
					converterFrequency[2*c+1:2*c] <= `PRT_FREQ_2M2;
				else
					converterFrequency[2*c+1:2*c] <= freqClass(freqSelect[2*c+1:2*c]);
			end
		end
	endgenerate

endmodule // prt_recovery_trigger_regs

// >>> prt_recovery_trigger_regs_bench.sv
`timescale 1ns/100ps
// ----------------
// Bench
// ----------------
module prt_recovery_trigger_regs_bench;
	logic core_clk = 0, reset_n = 0, regWrite = 0, regRead = 0, warmResetEvent = 0, nvmLoad = 0;
	logic [7:0] regAddr = 0, regWrData = 0, nvmFrequency = 8'h1b, regRdData, converterFrequency;
	logic [3:0] nvmTallyLimit = 4'h7, nvmConverterResets = 4'h6, sequencerKickPulse;
	logic [3:0] sequencerKickLevel, converterLogicReset;
	logic [1:0] nvmSpreadDepth = 2'h2, spreadDepth;
	logic nvmSpreadEnable = 1, powerDownAll, sleepOneCopy, sleepTwoCopy, spreadEnable;
	int n_fail = 0, n_compared = 0;
	always #5 core_clk = ~core_clk;
	prt_recovery_trigger_regs uut (.*);
	task chk(input [7:0] s, input [7:0] e);
		n_compared++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task put(input [7:0] a, input [7:0] d);
		regWrite = 1;
		regAddr = a;
		regWrData = d;
		@(negedge core_clk);
		regWrite = 0;
	endtask
	task wr(input [7:0] a, input [7:0] d);
		put(a, d);
		@(negedge core_clk);
	endtask
	task rd(input [7:0] a, input [7:0] e);
		regRead = 1;
		regAddr = a;
		@(negedge core_clk);
		regRead = 0;
		chk(regRdData, e);
		@(negedge core_clk);
	endtask
	task t_defaults;
		logic [7:0] a [8] = '{8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h8a, 8'h89};
		wr(8'h89, 8'hff);
		for (int i = 0; i < 8; i++) rd(a[i], 8'h00);
	endtask
	task t_tally;
		repeat (3) begin
			warmResetEvent = 1;
			@(negedge core_clk);
			warmResetEvent = 0;
			@(negedge core_clk);
		end
		wr(8'h83, 8'hff);
		rd(8'h83, 8'h03);
		wr(8'h84, 8'h03);
		@(negedge core_clk);
		chk(powerDownAll, 8'h01);
		put(8'h84, 8'h13);
		rd(8'h83, 8'h00);
		rd(8'h84, 8'h03);
		chk(powerDownAll, 8'h00);
		wr(8'h84, 8'h00);
	endtask
	task t_kick;
		put(8'h85, 8'ha5);
		chk(sequencerKickPulse, 8'h05);
		@(negedge core_clk);
		chk(sequencerKickPulse, 8'h00);
		chk(sequencerKickLevel, 8'h0a);
		rd(8'h85, 8'ha0);
		put(8'h85, 8'h0f);
		chk(sequencerKickPulse, 8'h0f);
		rd(8'h85, 8'h00);
	endtask
	task t_plain;
		wr(8'h86, 8'h02);
		chk({sleepTwoCopy, sleepOneCopy}, 8'h02);
		wr(8'h86, 8'h01);
		chk({sleepTwoCopy, sleepOneCopy}, 8'h01);
		rd(8'h86, 8'h01);
		wr(8'h87, 8'h09);
		chk(converterLogicReset, 8'h09);
		rd(8'h87, 8'h09);
		wr(8'h8a, 8'he4);
		chk(converterFrequency, 8'ha4);
		rd(8'h8a, 8'he4);
	endtask
	task t_spread;
		for (int i = 0; i < 4; i++) begin
			wr(8'h88, 8'h04 | i);
			chk(spreadDepth, (i == 3) ? 0 : i);
		end
		wr(8'h88, 8'h01);
		chk({spreadEnable, spreadDepth}, 8'h00);
	endtask
	task t_nvm;
		nvmLoad = 1;
		@(negedge core_clk);
		nvmLoad = 0;
		@(negedge core_clk);
		chk(converterLogicReset, 8'h06);
		chk({spreadEnable, spreadDepth}, 8'h06);
		chk(converterFrequency, 8'h1a);
		rd(8'h84, 8'h07);
	endtask
	task results;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(negedge core_clk);
		reset_n = 1;
		repeat (3) @(negedge core_clk);
		t_defaults;
		t_tally;
		t_kick;
		t_plain;
		t_spread;
		t_nvm;
		results;
	end
	initial begin
		#20000;
		n_fail++;
		results;
	end
endmodule // prt_recovery_trigger_regs_bench
